// [rpf_framer.sv]
// Packet framer: builds raw-distance and fused-inertial packets, byte-serial,
// through a small FIFO to the serial transmitter.
// Assumes all inputs are produced on clk_sys_i; the transmitter drains the FIFO.
// Holds one pending packet of each kind; a newer event replaces the older.
// Contract
// - Raw packet per measurement, sent after the coordinate packet finishes.
// - Raw packet only while raw-distance output is enabled.
// - Header is broadcast address, packet type, 16-bit code, length byte.
// - Data code selects layout: raw distances or processed inertial.
// - Length 36 for raw, 42 for inertial; payload from offset 5.
// - CRC-16 directly after payload, offsets 41 and 47; host verifies.
// - Raw payload: tag address, four six-byte items, unused address zero.
// - Each item carries 32-bit millimetre distance at item offset 1.
// - Item flag byte last; bit 0 marks invalid, rest zero.
// - Signed 64-bit epoch milliseconds emission time at payload offset 25.
// - 16-bit emission age follows timestamp at 33, then one reserved byte.
// - Inertial packet sent on each new inertial data set.
// - Beacon units: inertial packets at 100 Hz when fused output enabled.
// - Modem units: forward at update rate when forwarding enabled.
// - Inertial payload opens with signed 32-bit X, Y, Z millimetres.
// - Quaternion W, X, Y, Z signed 16-bit from offset 12.
// - Quaternion scaled so unit magnitude reads 10000.
// - Velocity X, Y, Z signed 16-bit mm/s at 20, 22, 24.
// - Acceleration X, Y, Z signed 16-bit mm/s2 at 26, 28, 30.
// - Flag byte at 38: bits 0-3 data unavailable; rest zero.
`timescale 1ns/1ps
`default_nettype none

module rpf_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("rpf_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    // Extra pointer bit tells full from empty
    wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire          empty = (wr_q == rd_q);
    wire          push  = ce_i && in_valid_i && !full;
    wire          pop   = ce_i && out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end

    // Storage needs no reset; pointers guard it
    always_ff @(posedge clk_sys_i) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
endmodule // rpf_fifo

// ---------------------------------------------------------------
// One distance item: address, distance, flag byte
// ---------------------------------------------------------------
module rpf_item_pack
    import rpf_pkg::*;
#(
    parameter int ITEM_W = RPF_ITEM_BYTES * 8
) (
    // Item fields
    input  wire rpf_dist_item_t item_i,
    // Packed bytes, first byte in the low bits
    output logic [ITEM_W-1:0]   bytes_o
);
    if (ITEM_W != RPF_ITEM_BYTES * 8) begin : g_chk
        $error("rpf_item_pack: ITEM_W must match the item layout");
    end

    // Unused slots send a zero address so the host skips them
    wire [7:0] addr_byte = item_i.used ? item_i.addr : 8'h00;
    wire [7:0] flag_byte = {7'h00, item_i.invalid};

    assign bytes_o = {flag_byte, item_i.dist_mm, addr_byte};
endmodule // rpf_item_pack

module rpf_framer
    import rpf_pkg::*;
#(
    parameter int IMU_PERIOD_CYC = RPF_IMU_PER_CYC,
    parameter int FIFO_DEPTH     = RPF_FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic          clk_sys_i,
    input  wire logic          sys_rst_i,
    input  wire logic          ce_i,
    // Settings
    input  wire logic          raw_dist_enable_i,
    input  wire logic          fused_inertial_output_enable_i,
    input  wire logic          inertial_forward_enable_i,
    input  wire logic          unit_is_modem_i,
    // Measurement events
    input  wire logic          meas_done_i,
    input  wire rpf_raw_meas_t meas_i,
    input  wire logic          coord_pkt_done_i,
    input  wire logic          imu_new_i,
    input  wire rpf_imu_t      imu_i,
    // Serial byte stream
    output logic               tx_valid_o,
    input  wire logic          tx_ready_i,
    output logic [7:0]         tx_data_o,
    // Status
    output logic               busy_o,
    output logic               frame_done_o
);
    localparam int BODY_W = RPF_MAX_BODY * 8;

    if (IMU_PERIOD_CYC < 1 || FIFO_DEPTH < 2) begin : g_chk
        $error("rpf_framer: IMU_PERIOD_CYC and FIFO_DEPTH out of range");
    end

    // Length bytes must match the layout, or the host mis-sizes frames
    if (RPF_HDR_BYTES + int'(RPF_LEN_RAW) != RPF_CRC_OFS_RAW ||
        RPF_HDR_BYTES + int'(RPF_LEN_IMU) != RPF_CRC_OFS_IMU ||
        RPF_MAX_BODY > 63) begin : g_len_chk
        $error("rpf_framer: frame layout does not fit the length bytes");
    end

    // ---------------------------------------------------------------
    // CRC step, one byte, reflected
    // ---------------------------------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ RPF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Raw frame image, byte 0 in the low bits
    // ---------------------------------------------------------------
    localparam int ITEM_W = RPF_ITEM_BYTES * 8;

    rpf_raw_meas_t              meas_q;
    rpf_imu_t                   imu_q;
    wire [RPF_ITEMS*ITEM_W-1:0] items_img;

    // Item 0 goes out first
    for (genvar k = 0; k < RPF_ITEMS; k++) begin : g_item
        rpf_item_pack #(
            .ITEM_W (ITEM_W)
        ) u_item (
            .item_i  (meas_q.item[k]),
            .bytes_o (items_img[k*ITEM_W +: ITEM_W])
        );
    end

    wire [RPF_CRC_OFS_RAW*8-1:0] raw_img = {
        8'h00,                 // reserved byte 35
        meas_q.age_ms,         // at 33
        meas_q.emit_ms,        // at 25
        items_img,
        meas_q.tag_addr,
        RPF_LEN_RAW,
        RPF_CODE_RAW,
        RPF_PKT_TYPE,
        RPF_ADDR_BCAST
    };

    // ---------------------------------------------------------------
    // Inertial frame image
    // ---------------------------------------------------------------
    // Upper flag bits and the tail bytes stay zero
    wire [7:0]                   imu_flags = {4'h0, imu_q.na};
    wire [RPF_CRC_OFS_IMU*8-1:0] imu_img = {
        24'h000000,            // reserved 39..41
        imu_flags,
        imu_q.ts_ms,
        8'h00,
        imu_q.beacon_addr,
        imu_q.acc_z, imu_q.acc_y, imu_q.acc_x,
        imu_q.vel_z, imu_q.vel_y, imu_q.vel_x,
        imu_q.q_z, imu_q.q_y, imu_q.q_x, imu_q.q_w,
        imu_q.pos_z, imu_q.pos_y, imu_q.pos_x,
        RPF_LEN_IMU,
        RPF_CODE_IMU,
        RPF_PKT_TYPE,
        RPF_ADDR_BCAST
    };

    // ---------------------------------------------------------------
    // Event gating
    // ---------------------------------------------------------------
    logic        raw_pend_q;
    logic        coord_seen_q;
    logic        imu_pend_q;
    logic [31:0] pace_q;
    rpf_state_t  state_q;
    rpf_state_t  state_d;
    logic [BODY_W-1:0] sh_q;
    logic [5:0]  left_q;
    logic [15:0] crc_q;
    logic        done_q;

    // Beacon units pace to 100 Hz; modem units forward every update
    wire imu_en   = unit_is_modem_i ? inertial_forward_enable_i
                                    : fused_inertial_output_enable_i;
    wire pace_ok  = unit_is_modem_i || (pace_q == 32'h0);
    wire imu_take = imu_new_i && imu_en && pace_ok;
    wire raw_take = meas_done_i && raw_dist_enable_i;
    wire raw_go   = raw_pend_q && (coord_seen_q || coord_pkt_done_i);
    wire idle     = (state_q == RPF_IDLE);
    wire start_raw = idle && raw_go;
    wire start_imu = idle && !raw_go && imu_pend_q;

    // ---------------------------------------------------------------
    // Byte selection toward the FIFO
    // ---------------------------------------------------------------
    logic       fifo_in_ready;
    wire  [7:0] body_byte = sh_q[7:0];
    wire  [7:0] push_byte = (state_q == RPF_BODY)   ? body_byte :
                            (state_q == RPF_CRC_LO) ? crc_q[7:0] : crc_q[15:8];
    wire        push_vld  = !idle;
    wire        step      = ce_i && push_vld && fifo_in_ready;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            raw_pend_q   <= 1'b0;
            coord_seen_q <= 1'b0;
        end else if (ce_i) begin
            if (raw_take) begin
                raw_pend_q   <= 1'b1;
                coord_seen_q <= 1'b0;
            end else if (start_raw) begin
                raw_pend_q   <= 1'b0;
                coord_seen_q <= 1'b0;
            end else if (coord_pkt_done_i && raw_pend_q) begin
                coord_seen_q <= 1'b1;
            end
        end
    end

    // Newest measurement wins while a packet waits
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            meas_q <= '0;
            imu_q  <= '0;
        end else if (ce_i) begin
            if (raw_take) meas_q <= meas_i;
            if (imu_take) imu_q  <= imu_i;
        end
    end

    // New sample beats the clear when both land together
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            imu_pend_q <= 1'b0;
        end else if (ce_i) begin
            if (imu_take)       imu_pend_q <= 1'b1;
            else if (start_imu) imu_pend_q <= 1'b0;
        end
    end

    // Pacing restarts from each accepted sample, not from a free tick
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pace_q <= '0;
        end else if (ce_i) begin
            if (imu_take)             pace_q <= 32'(IMU_PERIOD_CYC - 1);
            else if (pace_q != 32'h0) pace_q <= pace_q - 32'h1;
        end
    end

    // ---------------------------------------------------------------
    // Serialiser
    // ---------------------------------------------------------------
    wire              go        = start_raw || start_imu;
    wire [BODY_W-1:0] load_img  = start_raw ? BODY_W'(raw_img) : imu_img;
    wire [5:0]        load_len  = start_raw ? 6'(RPF_CRC_OFS_RAW)
                                            : 6'(RPF_CRC_OFS_IMU);
    wire              body_step = step && (state_q == RPF_BODY);
    wire              last_body = (left_q == 6'd1);

    // Check word follows the last body byte, low byte first
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RPF_IDLE:   if (go) state_d = RPF_BODY;
            RPF_BODY:   if (body_step && last_body) state_d = RPF_CRC_LO;
            RPF_CRC_LO: if (step) state_d = RPF_CRC_HI;
            RPF_CRC_HI: if (step) state_d = RPF_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= RPF_IDLE;
            done_q  <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            done_q  <= step && (state_q == RPF_CRC_HI);
        end
    end

    // Image loads whole at start, then drains a byte per accepted push
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sh_q   <= '0;
            left_q <= '0;
        end else if (ce_i) begin
            if (go) begin
                sh_q   <= load_img;
                left_q <= load_len;
            end else if (body_step) begin
                sh_q   <= sh_q >> 8;
                left_q <= left_q - 6'd1;
            end
        end
    end

    // Seeded in idle so every frame's check word starts fresh
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            crc_q <= RPF_CRC_INIT;
        end else if (ce_i) begin
            if (idle)           crc_q <= RPF_CRC_INIT;
            else if (body_step) crc_q <= crc_byte(crc_q, body_byte);
        end
    end

    rpf_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (push_vld),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_byte),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o)
    );

    assign busy_o       = !idle;
    assign frame_done_o = done_q;

endmodule // rpf_framer

`default_nettype wire

// [rpf_pkg.sv]
// Shared constants and carrier types for the ranging/inertial packet framer.
// Assumes little-endian byte order on the serial stream throughout.
package rpf_pkg;

    // ---------------------------------------------------------------
    // Frame header
    // ---------------------------------------------------------------
    localparam logic [7:0]  RPF_ADDR_BCAST  = 8'hFF;
    localparam logic [7:0]  RPF_PKT_TYPE    = 8'h47;
    localparam logic [15:0] RPF_CODE_RAW    = 16'h0084;
    localparam logic [15:0] RPF_CODE_IMU    = 16'h0005;
    localparam logic [7:0]  RPF_LEN_RAW     = 8'd36;
    localparam logic [7:0]  RPF_LEN_IMU     = 8'd42;
    localparam int          RPF_HDR_BYTES   = 5;
    localparam int          RPF_CRC_OFS_RAW = 41;
    localparam int          RPF_CRC_OFS_IMU = 47;
    localparam int          RPF_MAX_BODY    = RPF_CRC_OFS_IMU;
    localparam int          RPF_ITEMS       = 4;
    localparam int          RPF_ITEM_BYTES  = 6;

    // ---------------------------------------------------------------
    // Check word
    // ---------------------------------------------------------------
    localparam logic [15:0] RPF_CRC_INIT    = 16'hFFFF;
    localparam logic [15:0] RPF_CRC_POLY    = 16'hA001;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int          RPF_CLK_NS      = 10;
    localparam int          RPF_IMU_PER_NS  = 10_000_000;
    localparam int          RPF_IMU_PER_CYC = RPF_IMU_PER_NS / RPF_CLK_NS;
    localparam int          RPF_FIFO_DEPTH  = 16;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        used;
        logic        invalid;
        logic [7:0]  addr;
        logic [31:0] dist_mm;
    } rpf_dist_item_t;

    typedef struct packed {
        logic [7:0]     tag_addr;
        rpf_dist_item_t [RPF_ITEMS-1:0] item;
        logic [63:0]    emit_ms;
        logic [15:0]    age_ms;
    } rpf_raw_meas_t;

    typedef struct packed {
        logic signed [31:0] pos_x;
        logic signed [31:0] pos_y;
        logic signed [31:0] pos_z;
        logic signed [15:0] q_w;
        logic signed [15:0] q_x;
        logic signed [15:0] q_y;
        logic signed [15:0] q_z;
        logic signed [15:0] vel_x;
        logic signed [15:0] vel_y;
        logic signed [15:0] vel_z;
        logic signed [15:0] acc_x;
        logic signed [15:0] acc_y;
        logic signed [15:0] acc_z;
        logic [7:0]         beacon_addr;
        logic [31:0]        ts_ms;
        logic [3:0]         na;
    } rpf_imu_t;

    typedef enum logic [1:0] {
        RPF_IDLE,
        RPF_BODY,
        RPF_CRC_LO,
        RPF_CRC_HI
    } rpf_state_t;

endpackage

// [rpf_framer_asserts.sv]
// Stream and status checks for rpf_framer.
// Assumes ce_i is held high while checked.
`timescale 1ns/1ps
`default_nettype none
module rpf_framer_asserts
    import rpf_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    // Stream and status
    input wire logic       tx_valid_o,
    input wire logic       tx_ready_i,
    input wire logic [7:0] tx_data_o,
    input wire logic       busy_o,
    input wire logic       frame_done_o
);
    // ----
    // Busy run length
    // ----
    logic [9:0] run_q;
    always_ff @(posedge clk_sys_i) begin
        run_q <= busy_o ? run_q + 10'h1 : 10'h0;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    reset_idle_a:
        assert property ($fell(sys_rst_i) |-> !tx_valid_o && !busy_o && !frame_done_o)
        else $error("output active after reset");
    hdr_first_a:
        assert property ($rose(busy_o) && !tx_valid_o |=> tx_valid_o && tx_data_o == 8'hFF)
        else $error("frame does not open with broadcast byte");
    head_hold_a:
        assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte lost while stalled");
    done_pulse_a:
        assert property (frame_done_o |=> !frame_done_o)
        else $error("frame done longer than a cycle");
    done_idle_a:
        assert property (frame_done_o |-> !busy_o && $past(busy_o))
        else $error("frame done without busy ending");
    frame_len_a:
        assert property (frame_done_o |-> run_q >= 10'd43)
        else $error("frame shorter than a raw frame");
    busy_hold_a:
        assert property ($rose(busy_o) |-> busy_o[*8])
        else $error("busy dropped early");
    frame_bound_a:
        assert property ($rose(busy_o) |-> ##[43:1000] frame_done_o)
        else $error("frame never completed");
endmodule // rpf_framer_asserts

bind rpf_framer rpf_framer_asserts rpf_framer_asserts_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .busy_o(busy_o),
    .frame_done_o(frame_done_o));
`default_nettype wire

// [rpf_host_model.sv]
// Host model: drains the byte stream, stalls on request, checks each frame.
// Assumes frames arrive whole and back to back.
`timescale 1ns/1ps
`default_nettype none
module rpf_host_model
    import rpf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // Byte stream
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    output logic            ready_o = 1'b0,
    // Stall request
    input  wire logic       slow_i
);
    // ----
    // Receive and frame check
    // ----
    logic [7:0]  rx_q[$];
    logic [7:0]  fb[$];
    logic [15:0] rnd_q    = 16'hACE1;
    int          good_cnt = 0;

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = RPF_CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ RPF_CRC_POLY : c >> 1;
        end
        return c;
    endfunction

    // Sparse ready while slow, so the framer's buffer fills
    always @(negedge clk_sys_i) begin
        rnd_q   <= {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
        ready_o <= !slow_i || rnd_q[2:0] == 3'h0;
    end

    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fb.delete();
        end else if (valid_i && ready_o) begin
            rx_q.push_back(data_i);
            fb.push_back(data_i);
            // Length byte sizes the frame
            if (fb.size() > 4 && fb.size() == int'(fb[4]) + 7) begin
                if (crc16(fb[0:$-2]) === {fb[$], fb[$-1]}) good_cnt++;
                fb.delete();
            end
        end
    end
endmodule // rpf_host_model
`default_nettype wire

// [rpf_tb.sv]
// Bench for rpf_framer: random frames, refusals, pacing and ordering.
// Assumes rpf_host_model as the stream consumer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rpf_pkg::*;
    // ----
    // Signals
    // ----
    logic          clk_sys_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
    logic          raw_en = 1'b0, fio_en = 1'b0, fwd_en = 1'b0, modem = 1'b0;
    logic          meas_done = 1'b0, coord = 1'b0, imu_new = 1'b0;
    logic          tx_valid, tx_ready, busy, frame_done;
    logic [7:0]    tx_data;
    rpf_raw_meas_t meas = '0, m1;
    rpf_imu_t      imu = '0, d1, d2;
    logic [319:0]  w;
    logic [31:0]   lfsr_q = 32'h65F6;
    logic [7:0]    fr[$], exp_q[$];
    int            miscompares = 0, num_checks = 0, frames = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    rpf_framer #(.IMU_PERIOD_CYC(20)) rpf_framer_i (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .ce_i(1'b1), .raw_dist_enable_i(raw_en),
        .fused_inertial_output_enable_i(fio_en), .inertial_forward_enable_i(fwd_en),
        .unit_is_modem_i(modem), .meas_done_i(meas_done), .meas_i(meas),
        .coord_pkt_done_i(coord), .imu_new_i(imu_new), .imu_i(imu), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .tx_data_o(tx_data), .busy_o(busy), .frame_done_o(frame_done));
    rpf_host_model rpf_host_model_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .valid_i(tx_valid), .data_i(tx_data), .ready_o(tx_ready), .slow_i(slow));

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic put(input logic [127:0] v, input int n);
        for (int i = 0; i < n; i++) fr.push_back(v[8*i+:8]);
    endtask
    task automatic hdr(input logic [7:0] len, input logic [15:0] code);
        put(128'({len, code, 8'h47, 8'hFF}), 5);
    endtask
    task automatic close();
        put(128'(rpf_host_model_i.crc16(fr)), 2);
        exp_q = {exp_q, fr};
        fr.delete();
        frames++;
    endtask
    task automatic exp_raw(input rpf_raw_meas_t m);
        rpf_dist_item_t t;
        hdr(8'h24, 16'h0084);
        put(128'(m.tag_addr), 1);
        for (int i = 0; i < 4; i++) begin
            t = m.item[i];
            put(128'({7'h00, t.invalid, t.dist_mm, t.used ? t.addr : 8'h00}), 6);
        end
        put(128'({8'h00, m.age_ms, m.emit_ms}), 11);
        close();
    endtask
    task automatic exp_imu(input rpf_imu_t d);
        hdr(8'h2A, 16'h0005);
        put(128'({d.pos_z, d.pos_y, d.pos_x}), 12);
        put(128'({d.q_z, d.q_y, d.q_x, d.q_w}), 8);
        put(128'({d.acc_z, d.acc_y, d.acc_x, d.vel_z, d.vel_y, d.vel_x}), 12);
        put(128'({d.ts_ms, 8'h00, d.beacon_addr}), 6);
        put(128'({28'h0, d.na}), 4);
        close();
    endtask
    // One-cycle event pulse; fresh data rides along when asked
    task automatic ev(ref logic s, input bit fresh);
        w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        @(negedge clk_sys_i);
        if (fresh) begin
            meas = w[255:0];
            imu = w[299:0];
        end
        s = 1'b1;
        @(negedge clk_sys_i);
        s = 1'b0;
    endtask
    task automatic drain(input string name);
        int n;
        n = 0;
        repeat (4) @(negedge clk_sys_i);
        while ((busy !== 1'b0 || tx_valid !== 1'b0 ||
                rpf_host_model_i.rx_q.size() < exp_q.size()) && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 3000) begin
            miscompares++;
            finish_test();
        end else begin
            check(rpf_host_model_i.rx_q.size(), exp_q.size());
            foreach (exp_q[i]) check(rpf_host_model_i.rx_q[i], exp_q[i]);
            check(rpf_host_model_i.good_cnt, frames);
            $display("Test %s ended: %0d checks, %0d mismatches", name, num_checks, miscompares);
            exp_q.delete();
            rpf_host_model_i.rx_q.delete();
        end
    endtask

    // ----
    // Scenarios
    // ----
    initial begin
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        raw_en = 1'b1;
        slow = 1'b1;
        ev(meas_done, 1);
        m1 = meas;
        ev(coord, 0);
        ev(meas_done, 1);
        ev(coord, 0);
        ev(meas_done, 1); // Replaces the pending snapshot
        ev(coord, 0);
        exp_raw(m1);
        exp_raw(meas);
        drain("raw_burst");
        slow = 1'b0;
        ev(meas_done, 1);
        repeat (10) @(negedge clk_sys_i);
        check(rpf_host_model_i.rx_q.size(), 0);
        ev(coord, 0);
        exp_raw(meas);
        drain("raw_waits_coord");
        raw_en = 1'b0;
        ev(meas_done, 1);
        ev(coord, 0);
        fwd_en = 1'b1;
        ev(imu_new, 1);
        drain("both_refused");
        fio_en = 1'b1;
        ev(imu_new, 1);
        exp_imu(imu);
        ev(imu_new, 1);
        drain("imu_paced");
        ev(imu_new, 1);
        exp_imu(imu);
        drain("imu_period_over");
        modem = 1'b1;
        fio_en = 1'b0;
        raw_en = 1'b1;
        slow = 1'b1;
        ev(imu_new, 1);
        d1 = imu;
        ev(imu_new, 1);
        d2 = imu;
        ev(meas_done, 1);
        ev(coord, 0);
        exp_imu(d1);
        exp_raw(meas);
        exp_imu(d2);
        drain("modem_order");
        fwd_en = 1'b0;
        fio_en = 1'b1;
        ev(imu_new, 1);
        drain("modem_off");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
